/* logic/drm_pkg.sv */
// Constants, types and register map of the debug reset and interrupt mask block
package drm_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_PULSE_NS = 100;
    localparam int RST_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = $clog2(RST_CYCLES + 1);

    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_OPTION = 12'h004;
    localparam logic [11:0] OFS_GUARD = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;

    localparam int CTRL_SWRST_BIT = 0;
    localparam int OPT_BOOT_HI_BIT = 0;
    localparam int OPT_MAT_LO_BIT = 1;
    localparam int OPT_IFACE_LSB = 2;
    localparam int GUARD_GRAM_BIT = 0;
    localparam int GUARD_PERIPH_BIT = 1;
    localparam int STAT_CORE_LSB = 0;
    localparam int STAT_PRST_BIT = 16;
    localparam int STAT_PIRQ_LSB = 17;
    localparam int STAT_MASK_BIT = 20;
    localparam int MAX_CORES = 4;

    localparam logic [1:0] IFACE_JTAG = 2'h3;
    localparam logic [1:0] IFACE_SERIAL = 2'h1;
    localparam logic BOOT_HI_RESET = 1'h1;
    localparam logic MAT_LO_RESET = 1'h0;
    localparam logic [1:0] GUARD_RESET = 2'h3;

    localparam int IRQ_NUM = 3;
    localparam int IRQ_MASKABLE = 0;
    localparam int IRQ_FAST = 1;
    localparam int IRQ_FLOAT = 2;

    typedef enum logic [3:0] {
        DRM_RUN = 4'h1,
        DRM_BRK = 4'h2,
        DRM_STEP = 4'h4,
        DRM_HALT = 4'h8
    } drm_core_e;

    typedef enum logic [2:0] {
        RS_IDLE = 3'h1,
        RS_USER = 3'h2,
        RS_PROBE = 3'h4
    } drm_rst_e;

    typedef struct packed {
        logic connect;
        logic serial_link;
        logic reset_req;
    } drm_probe_s;

    typedef struct packed {
        logic break_req;
        logic run_req;
        logic step_req;
        logic bp_hit;
        logic halt_exec;
        logic step_done;
        logic wake;
    } drm_core_cmd_s;

endpackage : drm_pkg

/* logic/drm_pend.sv */
// Sticky pending flags where a new request wins over a clear
`timescale 1ns/1ps
module drm_pend
    import drm_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] q
);

    initial begin
        if (WIDTH < 1) $error("drm_pend needs WIDTH of at least 1");
    end

    wire [WIDTH-1:0] next_q = set | (q & ~clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) q <= '0;
        else q <= next_q;
    end

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set != '0) |=> ((q & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("pending request lost");

endmodule : drm_pend

/* logic/drm_core_ctl.sv */
// Per-core run, break, step and halt state tracking
`timescale 1ns/1ps
module drm_core_ctl
    import drm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire drm_core_cmd_s cmd,
    input wire logic force_break,
    input wire logic user_reset,
    output drm_core_e state
);

    drm_core_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            DRM_RUN: begin
                if (cmd.break_req || cmd.bp_hit) next_state = DRM_BRK;
                else if (cmd.halt_exec) next_state = DRM_HALT;
            end
            DRM_BRK: begin
                if (cmd.run_req) next_state = DRM_RUN;
                else if (cmd.step_req) next_state = DRM_STEP;
            end
            DRM_STEP: begin
                // Halt during a step never parks the core
                if (cmd.halt_exec || cmd.step_done || cmd.break_req) next_state = DRM_BRK;
            end
            DRM_HALT: begin
                if (cmd.break_req) next_state = DRM_BRK;
                else if (cmd.wake) next_state = DRM_RUN;
            end
            default: next_state = DRM_BRK;
        endcase
        if (user_reset) next_state = DRM_RUN;
        if (force_break) next_state = DRM_BRK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state <= DRM_RUN;
        else state <= next_state;
    end

    property p_halt_break;
        @(posedge pclk) disable iff (!presetn)
        (state == DRM_HALT && cmd.break_req && !user_reset) |=> (state == DRM_BRK);
    endproperty
    a_halt_break: assert property (p_halt_break) else $error("break did not end halt");

    property p_step_halt;
        @(posedge pclk) disable iff (!presetn)
        (state == DRM_STEP && cmd.halt_exec && !user_reset) |=> (state == DRM_BRK);
    endproperty
    a_step_halt: assert property (p_step_halt) else $error("halt entered while stepping");

endmodule : drm_core_ctl

/* logic/drm_top.sv */
// Debug-state reset and interrupt masking with APB register file
`timescale 1ns/1ps
module drm_top
    import drm_pkg::*;
#(
    parameter int N_CORES = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drm_probe_s probe,
    input wire drm_core_cmd_s [N_CORES-1:0] core_cmd,
    input wire logic pin_resetn,
    input wire logic sw_reset_req,
    input wire logic [IRQ_NUM-1:0] irq_in,
    output drm_core_e [N_CORES-1:0] core_state,
    output logic sys_reset,
    output logic [IRQ_NUM-1:0] irq_out,
    output logic boot_serial_prog,
    output logic boot_user_mat,
    output logic [1:0] iface_sel,
    output logic dbg_access_ok
);

    initial begin
        if (N_CORES < 1 || N_CORES > MAX_CORES) $error("N_CORES must be 1 to 4");
    end

    // Register state
    logic opt_boot_hi;
    logic opt_mat_lo;
    logic [1:0] opt_iface;
    logic [1:0] guard;
    logic boot_init;

    // Reset sequencing
    drm_rst_e rst_state;
    drm_rst_e next_rst;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic force_break;
    logic core_user_rst;
    logic pend_rst;
    logic [IRQ_NUM-1:0] pend_irq;

    // Reset pin synchroniser and edge detect
    logic pin_rst_m;
    logic pin_rst_s;
    logic pin_rst_q;

    // APB decode
    wire sel_ctrl = (paddr == OFS_CTRL);
    wire sel_opt = (paddr == OFS_OPTION);
    wire sel_guard = (paddr == OFS_GUARD);
    wire sel_stat = (paddr == OFS_STATUS);
    wire mapped = sel_ctrl | sel_opt | sel_guard | sel_stat;
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready & ~pslverr & pstrb[0];
    wire wr_ctrl = wr_en & sel_ctrl;
    wire wr_opt = wr_en & sel_opt;
    wire wr_guard = wr_en & sel_guard;
    wire ctrl_swrst = wr_ctrl & pwdata[CTRL_SWRST_BIT];

    // Debug state of the cores
    logic [N_CORES-1:0] in_debug;
    genvar gi;
    generate
        for (gi = 0; gi < N_CORES; gi++) begin : g_core
            drm_core_ctl u_core (
                .pclk(pclk),
                .presetn(presetn),
                .cmd(core_cmd[gi]),
                .force_break(force_break),
                .user_reset(core_user_rst),
                .state(core_state[gi])
            );
            assign in_debug[gi] = (core_state[gi] == DRM_BRK) || (core_state[gi] == DRM_STEP);
        end
    endgenerate

    // The mask follows break or step only; the debugger mask setting cannot open it
    wire mask_active = |in_debug;
    wire [4*N_CORES-1:0] core_vec = core_state;

    // User reset sources, pin relies on the target keeping it off during connect
    wire pin_evt = ~pin_rst_s & pin_rst_q;
    wire user_evt = pin_evt | sw_reset_req | ctrl_swrst;
    wire hold_rst = user_evt & mask_active;
    wire rst_go = (user_evt | pend_rst) & ~mask_active;
    wire cnt_done = (rst_cnt == '0);
    wire rst_start = (rst_state == RS_IDLE) && (next_rst != RS_IDLE);
    wire probe_start = probe.reset_req && (rst_state != RS_PROBE);

    always_comb begin
        next_rst = rst_state;
        case (rst_state)
            RS_IDLE: begin
                if (probe.reset_req) next_rst = RS_PROBE;
                else if (rst_go) next_rst = RS_USER;
            end
            RS_USER: begin
                if (probe.reset_req) next_rst = RS_PROBE;
                else if (cnt_done) next_rst = RS_IDLE;
            end
            RS_PROBE: begin
                if (cnt_done) next_rst = RS_IDLE;
            end
            default: next_rst = RS_IDLE;
        endcase
    end

    wire [RST_CNT_W-1:0] next_cnt = probe_start || rst_start ? RST_CNT_W'(RST_CYCLES - 1) :
                                    cnt_done ? rst_cnt : rst_cnt - 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_state <= RS_IDLE;
            rst_cnt <= '0;
            sys_reset <= 1'b0;
        end else begin
            rst_state <= next_rst;
            rst_cnt <= next_cnt;
            sys_reset <= (next_rst != RS_IDLE);
        end
    end

    // Cores restart after a user reset, stop after a probe reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_break <= 1'b0;
            core_user_rst <= 1'b0;
        end else begin
            force_break <= (rst_state == RS_PROBE) && cnt_done;
            core_user_rst <= (rst_state == RS_USER) && cnt_done && !probe.reset_req;
        end
    end

    // A probe reset already resets the system, so a held user reset is dropped
    drm_pend #(.WIDTH(1)) u_pend_rst (
        .pclk(pclk),
        .presetn(presetn),
        .set(hold_rst),
        .clr((rst_start && rst_state == RS_IDLE) || probe_start),
        .q(pend_rst)
    );

    // Unmasking clears pending interrupts: delivered, or discarded by a pending or running reset
    drm_pend #(.WIDTH(IRQ_NUM)) u_pend_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set(irq_in & {IRQ_NUM{mask_active}}),
        .clr({IRQ_NUM{~mask_active}}),
        .q(pend_irq)
    );

    wire irq_block = mask_active | pend_rst | (rst_state != RS_IDLE);
    wire [IRQ_NUM-1:0] next_irq = irq_block ? '0 : (irq_in | pend_irq);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_out <= '0;
        else irq_out <= next_irq;
    end

    // Two-flop pin synchroniser, edge taken after the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_rst_m <= 1'b1;
            pin_rst_s <= 1'b1;
            pin_rst_q <= 1'b1;
        end else begin
            pin_rst_m <= pin_resetn;
            pin_rst_s <= pin_rst_m;
            pin_rst_q <= pin_rst_s;
        end
    end

    // Option bits; serial connect rewrites boot-select and interface code
    wire serial_conn = probe.connect & probe.serial_link;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_boot_hi <= BOOT_HI_RESET;
            opt_mat_lo <= MAT_LO_RESET;
            opt_iface <= IFACE_JTAG;
        end else if (serial_conn) begin
            opt_boot_hi <= 1'b0;
            opt_iface <= IFACE_SERIAL;
        end else if (wr_opt) begin
            opt_boot_hi <= pwdata[OPT_BOOT_HI_BIT];
            opt_mat_lo <= pwdata[OPT_MAT_LO_BIT];
            opt_iface <= pwdata[OPT_IFACE_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) guard <= GUARD_RESET;
        else if (wr_guard) guard <= pwdata[GUARD_PERIPH_BIT:GUARD_GRAM_BIT];
    end

    // Boot source is caught after release and after every reset sequence
    wire boot_load = ~boot_init | force_break | core_user_rst;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_init <= 1'b0;
            boot_serial_prog <= 1'b0;
            boot_user_mat <= 1'b0;
            iface_sel <= 2'h0;
            dbg_access_ok <= 1'b0;
        end else begin
            boot_init <= 1'b1;
            if (boot_load) begin
                boot_serial_prog <= opt_boot_hi;
                boot_user_mat <= opt_mat_lo;
            end
            iface_sel <= opt_iface;
            dbg_access_ok <= guard[GUARD_GRAM_BIT] & guard[GUARD_PERIPH_BIT];
        end
    end

    // APB slave, zero wait states
    wire [31:0] stat_word = {11'h0, mask_active, pend_irq, pend_rst, 16'(core_vec)};
    wire [31:0] rd_word = sel_opt ? {28'h0, opt_iface, opt_mat_lo, opt_boot_hi} :
                          sel_guard ? {30'h0, guard} :
                          sel_stat ? stat_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? rd_word : 32'h0;
        end
    end

    // Checks
    sequence s_probe_end;
        (rst_state == RS_PROBE) && cnt_done;
    endsequence

    property p_probe_break;
        @(posedge pclk) disable iff (!presetn)
        s_probe_end ##1 1'b1 |=> (in_debug == {N_CORES{1'b1}});
    endproperty
    a_probe_break: assert property (p_probe_break) else $error("cores not in break after probe reset");

    property p_probe_reset;
        @(posedge pclk) disable iff (!presetn)
        probe.reset_req |=> sys_reset && (rst_state == RS_PROBE);
    endproperty
    a_probe_reset: assert property (p_probe_reset) else $error("probe reset not applied");

    property p_mask_hold;
        @(posedge pclk) disable iff (!presetn)
        (hold_rst && rst_state == RS_IDLE && !probe.reset_req) |=> pend_rst && !sys_reset;
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("masked reset not held");

    property p_pend_run;
        @(posedge pclk) disable iff (!presetn)
        (pend_rst && !mask_active && rst_state == RS_IDLE) |=> sys_reset ##(RST_CYCLES) !sys_reset;
    endproperty
    a_pend_run: assert property (p_pend_run) else $error("pending reset not carried out");

    property p_irq_mask;
        @(posedge pclk) disable iff (!presetn)
        mask_active |=> (irq_out == '0);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt passed while masked");

    property p_irq_service;
        @(posedge pclk) disable iff (!presetn)
        (!mask_active && !irq_block && pend_irq != '0) |=> ((irq_out & $past(pend_irq)) == $past(pend_irq));
    endproperty
    a_irq_service: assert property (p_irq_service) else $error("pending interrupt not serviced");

    property p_discard;
        @(posedge pclk) disable iff (!presetn)
        (!mask_active && pend_rst) |=> (pend_irq == '0) && (irq_out == '0);
    endproperty
    a_discard: assert property (p_discard) else $error("interrupts kept over pending reset");

    property p_serial_conn;
        @(posedge pclk) disable iff (!presetn)
        serial_conn |=> (opt_iface == IFACE_SERIAL) && !opt_boot_hi ##1 (iface_sel == IFACE_SERIAL);
    endproperty
    a_serial_conn: assert property (p_serial_conn) else $error("serial connect not recorded");

    property p_guard;
        @(posedge pclk) disable iff (!presetn)
        boot_init |-> (dbg_access_ok == $past(guard[GUARD_GRAM_BIT] & guard[GUARD_PERIPH_BIT]));
    endproperty
    a_guard: assert property (p_guard) else $error("debug access flag wrong");

    property p_boot_load;
        @(posedge pclk) disable iff (!presetn)
        !boot_init |=> (boot_serial_prog == $past(opt_boot_hi)) && (boot_user_mat == $past(opt_mat_lo));
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("boot source not latched");

endmodule : drm_top

/* logic/drm_top_fix.sv */
// Holds no logic; the block lives in drm_top

/* tb/drm_probe_model.sv */
// Behavioural model of the external debug probe side
`timescale 1ns/1ps
module drm_probe_model
    import drm_pkg::*;
(
    input wire logic pclk,
    output drm_probe_s probe
);

    initial begin
        probe = '0;
    end

    // Serial link stays selected while the probe operates
    // Caller keeps the reset pin released while this runs
    task connect_serial();
        @(posedge pclk);
        probe.connect <= 1'h1;
        probe.serial_link <= 1'h1;
        @(posedge pclk);
        probe.connect <= 1'h0;
    endtask : connect_serial

    task probe_reset();
        @(posedge pclk);
        probe.reset_req <= 1'h1;
        @(posedge pclk);
        probe.reset_req <= 1'h0;
    endtask : probe_reset

endmodule : drm_probe_model

/* tb/debug_reset_interrupt_mask_tb.sv */
// Self-checking bench for the debug reset and interrupt mask block
`timescale 1ns/1ps
module debug_reset_interrupt_mask_tb
    import drm_pkg::*;
;
    localparam int NC = 2;
    localparam logic [6:0] CMD_BRK = 7'h40;
    localparam logic [6:0] CMD_RUN = 7'h20;
    localparam logic [6:0] CMD_STEP = 7'h10;
    localparam logic [6:0] CMD_BP = 7'h08;
    localparam logic [6:0] CMD_HALT = 7'h04;

    logic pclk = 1'h0;
    logic presetn;
    logic [11:0] paddr;
    logic psel, penable, pwrite;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, err;
    drm_probe_s probe;
    drm_core_cmd_s [NC-1:0] core_cmd;
    logic pin_resetn, sw_reset_req, sys_reset;
    logic [IRQ_NUM-1:0] irq_in, irq_out, seen;
    drm_core_e [NC-1:0] core_state;
    logic boot_serial_prog, boot_user_mat, dbg_access_ok;
    logic [1:0] iface_sel;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int len;

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    drm_top #(.N_CORES(NC)) u_drm_top (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .probe(probe), .core_cmd(core_cmd), .pin_resetn(pin_resetn),
        .sw_reset_req(sw_reset_req), .irq_in(irq_in), .core_state(core_state),
        .sys_reset(sys_reset), .irq_out(irq_out), .boot_serial_prog(boot_serial_prog),
        .boot_user_mat(boot_user_mat), .iface_sel(iface_sel), .dbg_access_ok(dbg_access_ok)
    );

    drm_probe_model u_drm_probe_model (.pclk(pclk), .probe(probe));

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check

    // Access held until pready is seen high at a rising edge; data taken there
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task cmd(input int i, input logic [6:0] c);
        @(posedge pclk);
        core_cmd[i] <= drm_core_cmd_s'(c);
        @(posedge pclk);
        core_cmd[i] <= '0;
        @(negedge pclk);
    endtask : cmd

    // Length of the next reset pulse; also gathers any interrupt seen meanwhile
    task rst_len(output int n);
        int k;
        n = 0;
        for (k = 0; k < 20 && sys_reset !== 1'h1; k++) begin
            @(negedge pclk);
            seen = seen | irq_out;
        end
        while (sys_reset === 1'h1 && n < 40) begin
            n++;
            @(negedge pclk);
            seen = seen | irq_out;
        end
    endtask : rst_len

    task tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // Tests need well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        core_cmd = '0;
        pin_resetn = 1'h1;
        sw_reset_req = 1'h0;
        irq_in = 3'h0;
        seen = 3'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(negedge pclk);
        check(boot_serial_prog, 1);
        check(boot_user_mat, 0);
        check(iface_sel, 3);
        check(dbg_access_ok, 1);
        apb(0, OFS_OPTION, 0);
        check(rd, 32'hD);
        apb(0, 12'h010, 0);
        check(err, 1);
        // Strobe-less write must leave the permits alone
        pstrb <= 4'h0;
        apb(1, OFS_GUARD, 0);
        pstrb <= 4'hF;
        apb(0, OFS_GUARD, 0);
        check(rd, 32'h3);
        apb(1, OFS_GUARD, 0);
        repeat (2) @(negedge pclk);
        check(dbg_access_ok, 0);
        apb(1, OFS_GUARD, 3);
        u_drm_probe_model.connect_serial();
        repeat (2) @(negedge pclk);
        // Boot pins only relatch on a reset sequence
        check(boot_serial_prog, 1);
        check(iface_sel, 1);
        check(dbg_access_ok, 1);
        apb(0, OFS_OPTION, 0);
        check(rd, 32'h4);
        apb(1, OFS_OPTION, 32'h6);
        cmd(0, CMD_BRK);
        check(core_state[0], DRM_BRK);
        @(posedge pclk);
        sw_reset_req <= 1'h1;
        irq_in <= 3'h1;
        @(posedge pclk);
        sw_reset_req <= 1'h0;
        repeat (12) begin
            @(negedge pclk);
            check({sys_reset, irq_out}, 0);
        end
        @(posedge pclk);
        irq_in <= 3'h0;
        apb(0, OFS_STATUS, 0);
        check(rd, 32'h130012);
        seen = 3'h0;
        cmd(0, CMD_RUN);
        rst_len(len);
        check(len, RST_CYCLES);
        check(seen, 0);
        apb(0, OFS_STATUS, 0);
        check(rd, 32'h11);
        cmd(1, CMD_BRK);
        @(posedge pclk);
        irq_in <= 3'h7;
        repeat (3) @(posedge pclk);
        irq_in <= 3'h0;
        seen = 3'h0;
        cmd(1, CMD_RUN);
        repeat (4) begin
            @(negedge pclk);
            seen = seen | irq_out;
        end
        check(seen, 7);
        cmd(1, CMD_BRK);
        cmd(1, CMD_STEP);
        check(core_state[1], DRM_STEP);
        @(posedge pclk);
        irq_in <= 3'h2;
        repeat (3) begin
            @(negedge pclk);
            check(irq_out, 0);
        end
        @(posedge pclk);
        irq_in <= 3'h0;
        cmd(1, CMD_HALT);
        check(core_state[1], DRM_BRK);
        cmd(1, CMD_RUN);
        cmd(0, CMD_HALT);
        check(core_state[0], DRM_HALT);
        cmd(0, CMD_BRK);
        check(core_state[0], DRM_BRK);
        cmd(0, CMD_RUN);
        cmd(0, CMD_BP);
        check(core_state[0], DRM_BRK);
        u_drm_probe_model.probe_reset();
        rst_len(len);
        check(len, RST_CYCLES);
        repeat (2) @(negedge pclk);
        check({core_state[1], core_state[0]}, {DRM_BRK, DRM_BRK});
        check(boot_user_mat, 1);
        check(boot_serial_prog, 0);
        cmd(0, CMD_RUN);
        cmd(1, CMD_RUN);
        // Pin reset only while the program runs
        @(posedge pclk);
        pin_resetn <= 1'h0;
        rst_len(len);
        check(len, RST_CYCLES);
        @(posedge pclk);
        pin_resetn <= 1'h1;
        apb(1, OFS_CTRL, 1);
        rst_len(len);
        check(len, RST_CYCLES);
        apb(0, OFS_CTRL, 0);
        check(rd, 0);
        tally_and_finish();
    end

endmodule : debug_reset_interrupt_mask_tb
